// ---- fpp_host.v ----
// Host controller for a byte-wide fast parallel configuration port.
// Assumes an AXI4-Lite master on ref_clk and open-drain status lines pulled up on the board.
// Functional notes
// RULE_01: Device waits enable delay then 299 user clocks before user mode.
// RULE_02: Device releases configuration-complete one byte before the final byte.
// RULE_03: Initialization-complete floats high early, device pulls it low after option bit.
// RULE_04: Device releases initialization-complete at end of initialization; rise marks user mode.
// RULE_05: Host senses initialization-complete rising edge as entry into user mode.
// RULE_06: Device drops I/O pull-ups and runs pins as design assigns in user mode.
// RULE_07: Host holds byte clock and data bus at fixed levels after configuration.
// RULE_08: Data bus pins become tristated user I/O by default in user mode.
// RULE_09: Byte clock may halt indefinitely; device keeps state during the pause.
// RULE_10: With compression, halt clock only three cycles after last byte latch.
// RULE_11: On resume, host presents next byte before the first rising clock edge.
// RULE_12: Device pulls status low on error and resets itself internally.
// RULE_13: Auto-restart frees status within 100 us; host restarts without request pulse.
// RULE_14: Without auto-restart, host pulses configuration request low at least 2 us.
// RULE_15: Host restarts if stream ends without completion or initialization-complete rising.
// RULE_16: Host keeps user clock toggling while status is low during restart.
// RULE_17: Request low in user mode drives status and completion low; reload follows.
// RULE_18: Chained device drives chain-enable out low; next starts within one clock.
// RULE_19: Shared completion line makes all chained devices enter user mode together.
// RULE_20: Any chained error halts chain; host reconfigures whole chain.
// RULE_21: One decompression/security setting for the whole chain.
// RULE_22: Same-data devices ground chain-enable inputs and load identical bytes together.
// RULE_23: Device captures one byte per byte-clock rise without compression.
// RULE_24: With compression device captures every fourth rise and processes three more.
// RULE_25: Device releases completion line after the next-to-last byte.
// RULE_26: Device ignores byte clock and data while chain-enable input is high.
`timescale 1ns/10ps
`include "fpp_host_defines.vh"
module fpp_host #(
  parameter BYTE_HALF   = 2,
  parameter USER_HALF   = 2,
  parameter RESTART_CYC = 20000,
  parameter DONE_CYC    = 20000
) (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire [3:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [3:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  output reg         configRequestN,
  input  wire        statusLineN,
  input  wire        configDone,
  input  wire        initDone,
  output reg         configByteClock,
  output reg  [7:0]  configData,
  output reg         userStartupClock
);
  localparam integer REQ_CYC = (`REQ_LOW_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam integer ST2_CYC = (`ST2CK_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam [7:0] S_IDLE = 8'h01, S_PULSE = 8'h02, S_WAITST = 8'h04, S_SETUP = 8'h08;
  localparam [7:0] S_LOAD = 8'h10, S_INIT = 8'h20, S_USER = 8'h40, S_ERR = 8'h80;

  // Two-stage synchronisers for the three board lines
  wire [2:0] pinIn = {initDone, configDone, statusLineN};
  wire [2:0] syncBits;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg meta_q;
      reg sync_q;
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pinIn[gi];
          sync_q <= meta_q;
        end
      end
      assign syncBits[gi] = sync_q;
    end
  endgenerate
  wire statusHigh = syncBits[0];
  wire doneHigh   = syncBits[1];
  wire initHigh   = syncBits[2];
  reg  initPrev_q;

  reg [7:0]  state_q;
  reg [4:0]  ctrl_q;
  reg [31:0] timer_q;
  reg        error_q;
  reg        noDone_q;
  reg        holdValid_q;
  reg [7:0]  holdByte_q;
  reg        holdLast_q;
  reg        byteBusy_q;
  reg [2:0]  risesLeft_q;
  reg        lastSent_q;
  reg        streamEnd_q;
  reg [7:0]  byteDiv_q;
  reg [7:0]  userDiv_q;

  // Write decode: a data write waits until the single holding byte is free
  wire wrDataAddr = (awaddr == `REG_DATA);
  wire wrKnown    = (awaddr == `REG_CTRL) || wrDataAddr;
  wire wrTake     = awvalid && wvalid && !awready && !bvalid && !(wrDataAddr && holdValid_q);
  wire ctrlWr     = wrTake && (awaddr == `REG_CTRL) && wstrb[0];
  wire dataWr     = wrTake && wrDataAddr && wstrb[0];
  wire startCmd   = ctrlWr && wdata[`CTRL_START];
  wire abortCmd   = ctrlWr && wdata[`CTRL_ABORT];
  wire tick       = (byteDiv_q == 8'h00);
  wire byteFinish = (state_q == S_LOAD) && tick && configByteClock && byteBusy_q
                    && (risesLeft_q == 3'h0);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rresp   <= 2'h0;
      rdata   <= 32'h0000_0000;
    end else begin
      awready <= wrTake;
      wready  <= wrTake;
      if (wrTake) begin
        bvalid <= 1'b1;
        bresp  <= wrKnown ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && !arready && !rvalid) begin
        rvalid <= 1'b1;
        rresp  <= 2'h0;
        case (araddr)
          `REG_CTRL:   rdata <= {27'h0, ctrl_q};
          `REG_STATUS: rdata <= {23'h0, streamEnd_q, initHigh, doneHigh, statusHigh,
                                 noDone_q, !holdValid_q, error_q, state_q == S_USER,
                                 !(state_q == S_IDLE || state_q == S_USER || state_q == S_ERR)};
          `REG_DATA:   rdata <= {23'h0, holdLast_q, holdByte_q};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= 2'h2;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Holding byte and byte-clock engine
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q          <= `CTRL_RESET;
      holdValid_q     <= 1'b0;
      holdByte_q      <= 8'h00;
      holdLast_q      <= 1'b0;
      byteBusy_q      <= 1'b0;
      risesLeft_q     <= 3'h0;
      lastSent_q      <= 1'b0;
      configByteClock <= 1'b0;
      configData      <= 8'h00;
      byteDiv_q       <= 8'h00;
    end else begin
      if (ctrlWr)
        ctrl_q <= {wdata[`CTRL_USERCLK:`CTRL_COMPRESS], 1'b0};
      byteDiv_q <= tick ? BYTE_HALF[7:0] - 8'h01 : byteDiv_q - 8'h01;
      if (dataWr) begin
        holdValid_q <= 1'b1;
        holdByte_q  <= wdata[7:0];
        holdLast_q  <= wdata[`DATA_LAST];
      end
      if (abortCmd || state_q != S_LOAD) begin
        // Clock parks low and data stays driven outside loading
        configByteClock <= 1'b0;                                            // RULE_07
        byteBusy_q      <= 1'b0;
        risesLeft_q     <= 3'h0;
        if (abortCmd)
          holdValid_q <= 1'b0;
        if (state_q == S_SETUP)
          lastSent_q <= 1'b0;
      end else if (tick) begin
        if (configByteClock) begin
          configByteClock <= 1'b0;
          if (risesLeft_q == 3'h0)
            byteBusy_q <= 1'b0;
        end else if (byteBusy_q && risesLeft_q != 3'h0) begin
          configByteClock <= 1'b1;
          risesLeft_q     <= risesLeft_q - 3'h1;
        end else if (!byteBusy_q && holdValid_q && !lastSent_q) begin
          // Byte set up while clock is low; the rise comes a half period later
          configData  <= holdByte_q;                                         // RULE_11
          byteBusy_q  <= 1'b1;
          // One rise per byte, or four so the device gets three processing edges
          risesLeft_q <= ctrl_q[`CTRL_COMPRESS] ? `BYTES_COMPRESS : 3'h1;  // RULE_24 RULE_10 RULE_21
          holdValid_q <= 1'b0;
          lastSent_q  <= holdLast_q;
        end
        // No byte waiting: clock simply halts low
      end                                                                    // RULE_09
    end
  end

  // Sequencer
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q        <= S_IDLE;
      timer_q        <= 32'h0000_0000;
      configRequestN <= 1'b1;
      error_q        <= 1'b0;
      noDone_q       <= 1'b0;
      streamEnd_q    <= 1'b0;
      initPrev_q     <= 1'b0;
    end else begin
      initPrev_q <= initHigh;
      if (timer_q != 32'h0000_0000)
        timer_q <= timer_q - 32'h0000_0001;
      if (abortCmd) begin
        state_q        <= S_IDLE;
        configRequestN <= 1'b1;
      end else if (startCmd && (state_q == S_IDLE || state_q == S_USER || state_q == S_ERR)) begin
        // Restart and user-mode reload both pulse the request low
        state_q        <= S_PULSE;                                           // RULE_14 RULE_17
        configRequestN <= 1'b0;
        timer_q        <= REQ_CYC;
        error_q        <= 1'b0;
        noDone_q       <= 1'b0;
      end else begin
        case (state_q)
          S_PULSE: begin
            if (timer_q == 32'h0000_0000) begin
              configRequestN <= 1'b1;
              state_q        <= S_WAITST;
            end
          end
          S_WAITST: begin
            if (statusHigh) begin
              state_q <= S_SETUP;
              timer_q <= ST2_CYC;
            end
          end
          S_SETUP: begin
            streamEnd_q <= 1'b0;
            if (timer_q == 32'h0000_0000)
              state_q <= S_LOAD;
          end
          S_LOAD: begin
            if (byteFinish && lastSent_q) begin
              streamEnd_q <= 1'b1;
              timer_q     <= DONE_CYC;
            end
            if (!statusHigh) begin
              // Whole chain halts on a shared status low
              state_q <= S_ERR;                                              // RULE_12 RULE_20
              error_q <= 1'b1;
            end else if (streamEnd_q && doneHigh) begin
              // Completion may already stand before the final byte went out
              state_q <= S_INIT;                                             // RULE_02 RULE_25 RULE_19
              timer_q <= RESTART_CYC;
            end else if (streamEnd_q && timer_q == 32'h0000_0000) begin
              state_q  <= S_ERR;                                             // RULE_15
              error_q  <= 1'b1;
              noDone_q <= 1'b1;
            end
          end
          S_INIT: begin
            if (!statusHigh) begin
              state_q <= S_ERR;
              error_q <= 1'b1;
            end else if (initHigh && !initPrev_q) begin
              state_q <= S_USER;                                             // RULE_05 RULE_04
            end else if (timer_q == 32'h0000_0000) begin
              // Without the init-done pin, the wait itself ends initialization
              state_q  <= ctrl_q[`CTRL_USEINIT] ? S_ERR : S_USER;            // RULE_15 RULE_01
              error_q  <= ctrl_q[`CTRL_USEINIT];
              noDone_q <= ctrl_q[`CTRL_USEINIT];
            end
          end
          S_ERR: begin
            // Released status lets the host reload without a request pulse
            if (ctrl_q[`CTRL_AUTORST] && statusHigh) begin
              state_q <= S_SETUP;                                            // RULE_13 RULE_20
              timer_q <= ST2_CYC;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Free-running user start-up clock; keeps toggling through status-low restarts
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      userDiv_q        <= 8'h00;
      userStartupClock <= 1'b0;
    end else if (!ctrl_q[`CTRL_USERCLK]) begin
      userDiv_q        <= 8'h00;
      userStartupClock <= 1'b0;
    end else if (userDiv_q == 8'h00) begin
      userDiv_q        <= USER_HALF[7:0] - 8'h01;
      userStartupClock <= !userStartupClock;                                 // RULE_16 RULE_01
    end else begin
      userDiv_q <= userDiv_q - 8'h01;
    end
  end
endmodule

// ---- fpp_host_defines.vh ----
// Register map, field positions and timing figures of the configuration host.
// Included by the host design; holds definitions only.
`ifndef FPP_HOST_DEFINES_VH
`define FPP_HOST_DEFINES_VH

`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_DATA        4'h8

`define CTRL_START      0
`define CTRL_COMPRESS   1
`define CTRL_AUTORST    2
`define CTRL_USEINIT    3
`define CTRL_USERCLK    4
`define CTRL_ABORT      5
`define CTRL_RESET      5'h00

`define DATA_LAST       8

`define ST_BUSY         0
`define ST_USERMODE     1
`define ST_ERROR        2
`define ST_HOLDEMPTY    3
`define ST_NODONE       4
`define ST_STATUSLINE   5
`define ST_CFGDONE      6
`define ST_INITDONE     7
`define ST_STREAMEND    8

`define CLK_PERIOD_PS   5000
`define REQ_LOW_NS      2000
`define ST2CK_NS        2000
`define RESTART_US      100
`define BYTES_COMPRESS  3'h4

`endif

// ---- fpp_host_checker.sv ----
// Concurrent checks on the configuration host's AXI and device-side pins.
// Assumes the device's open-drain lines arrive as resolved levels (pulled up).
`timescale 1ns/10ps
module fpp_host_checker (
  input wire       ref_clk,
  input wire       rstn,
  input wire       awready,
  input wire       wready,
  input wire       bvalid,
  input wire       bready,
  input wire       arready,
  input wire       rvalid,
  input wire       rready,
  input wire       configRequestN,
  input wire       statusLineN,
  input wire       configByteClock,
  input wire [7:0] configData
);
  localparam int MinLow = 400;
  logic [15:0] reqLowQ;
  logic [15:0] stHighQ;
  // Saturating, so long user-mode spans cannot wrap and fake a short wait
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reqLowQ <= 16'h0000;
      stHighQ <= 16'h0000;
    end else begin
      reqLowQ <= configRequestN ? 16'h0000 : reqLowQ + {15'h0000, reqLowQ != 16'hFFFF};
      stHighQ <= !statusLineN ? 16'h0000 : stHighQ + {15'h0000, stHighQ != 16'hFFFF};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence byteRise;
    !configByteClock ##1 configByteClock;
  endsequence
  sequence statusHeld;
    !statusLineN [*6];
  endsequence
  a_req_low_width: assert property ($rose(configRequestN) |-> reqLowQ >= MinLow)
    else $error("request pulse too short");
  a_status_setup: assert property (byteRise |-> stHighQ >= MinLow)
    else $error("byte clock too soon after status release");
  a_data_setup: assert property (byteRise |-> $stable(configData))
    else $error("data changed at the byte clock rise");
  a_data_hold: assert property (configByteClock && $past(configByteClock) |-> $stable(configData))
    else $error("data changed while byte clock high");
  a_clk_high_min: assert property (byteRise |=> configByteClock)
    else $error("byte clock high phase too short");
  a_idle_request: assert property (!configRequestN |-> !configByteClock)
    else $error("byte clock active during request");
  a_halt_error: assert property (statusHeld |-> !$rose(configByteClock))
    else $error("byte clock kept running with status low");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  a_ready_pair: assert property (awready |-> wready && bvalid)
    else $error("write channels not answered together");
  a_read_answer: assert property (arready |-> rvalid)
    else $error("read address taken without data");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("read data dropped early");
endmodule
bind fpp_host fpp_host_checker i_fpp_host_checker (
  .ref_clk(ref_clk), .rstn(rstn), .awready(awready), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arready(arready), .rvalid(rvalid), .rready(rready),
  .configRequestN(configRequestN), .statusLineN(statusLineN),
  .configByteClock(configByteClock), .configData(configData)
);

// ---- fpp_device_model.sv ----
// Behavioural model of the device on the fast parallel load pins.
// Open-drain lines are given as resolved levels; the board pull-ups are implied.
`timescale 1ns/10ps
module fpp_device_model #(
  parameter NBYTES   = 4,
  parameter INIT_CYC = 30
) (
  input  wire       ref_clk,
  input  wire       configRequestN,
  input  wire       configByteClock,
  input  wire [7:0] configData,
  input  wire       compress,
  input  wire       injectErr,
  output reg        statusLineN = 1'h1,
  output reg        configDone = 1'h0,
  output reg        initDone = 1'h1
);
  reg        prevClk = 1'h0;
  reg        errQ = 1'h0;
  reg        userMode = 1'h0;
  // Single device: chain-enable input grounded
  wire       chainEnableInN = 1'h0;
  integer    rises = 0;
  integer    nBytes = 0;
  integer    initCnt = 0;
  reg  [7:0] got [0:7];
  always @(posedge ref_clk) begin
    prevClk <= configByteClock;
    if (!configRequestN || errQ || injectErr) begin
      statusLineN <= 1'h0;
      configDone <= 1'h0;
      userMode <= 1'h0;
      rises = 0;
      nBytes = 0;
      initCnt = 0;
      // Error latches until the host pulses the request
      errQ <= configRequestN;
      if (!configRequestN) initDone <= 1'h1;
    end else begin
      statusLineN <= 1'h1;
      if (configByteClock && !prevClk && !configDone && !chainEnableInN) begin
        rises = rises + 1;
        if (!compress || rises % 4 == 1) begin
          got[nBytes] = configData;
          nBytes = nBytes + 1;
          initDone <= 1'h0;
        end
        if (nBytes == NBYTES - 1 && (!compress || rises % 4 == 0)) configDone <= 1'h1;
      end
      if (configDone) initCnt = initCnt + 1;
      if (initCnt == INIT_CYC) initDone <= 1'h1;
      if (initCnt == INIT_CYC) userMode <= 1'h1;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench: AXI4-Lite master, device model on the load pins.
// Assumes ref_clk at 200 MHz and the host's short timers.
`timescale 1ns/10ps
`include "fpp_host_defines.vh"
module testbench;
  reg         ref_clk = 1'h0;
  reg         rstn = 1'h0;
  reg  [3:0]  awaddr = 4'h0;
  reg  [3:0]  araddr = 4'h0;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg         injectErr = 1'h0, compress = 1'h0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        configRequestN, statusLineN, configDone, initDone, configByteClock;
  wire        userStartupClock;
  reg         ucA;
  wire [7:0]  configData;
  integer     n_fail = 0, num_checks = 0;
  reg  [31:0] rd;
  reg  [1:0]  rs;
  reg  [7:0]  stream [0:3];
  fpp_host #(.RESTART_CYC(50), .DONE_CYC(50)) i_fpp_host (
    .ref_clk(ref_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .configRequestN(configRequestN), .statusLineN(statusLineN), .configDone(configDone),
    .initDone(initDone), .configByteClock(configByteClock), .configData(configData),
    .userStartupClock(userStartupClock));
  fpp_device_model i_fpp_device_model (
    .ref_clk(ref_clk), .configRequestN(configRequestN), .configByteClock(configByteClock),
    .configData(configData), .compress(compress), .injectErr(injectErr),
    .statusLineN(statusLineN), .configDone(configDone), .initDone(initDone));
  always #2.5 ref_clk = ~ref_clk;
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task axiWrite(input [3:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
        @(posedge ref_clk);
        if (awready) awvalid <= 1'h0;
        if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      check({30'h0, bresp}, 32'h0);
      bready <= 1'h0;
    end
  endtask
  task axiRead(input [3:0] a);
    begin
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
        @(posedge ref_clk);
        if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
    end
  endtask
  task testReset;
    begin
      check({31'h0, configRequestN}, 32'h1);
      axiRead(`REG_CTRL);
      check(rd, {27'h0, `CTRL_RESET});
      axiRead(`REG_STATUS);
      check(rd & 32'h10F, 32'h8);
      axiRead(4'hC);
      check({30'h0, rs}, 32'h2);
    end
  endtask
  task testLoad(input cmp);
    integer k;
    begin
      compress <= cmp;
      axiWrite(`REG_CTRL, 32'h9 | {30'h0, cmp, 1'h0});
      for (k = 0; k < 4; k = k + 1)
        axiWrite(`REG_DATA, {23'h0, k == 3, stream[k]});
      rd = 32'h0;
      while (!rd[`ST_USERMODE]) axiRead(`REG_STATUS);
      check({31'h0, configByteClock}, 32'h0);
      check({24'h0, configData}, {24'h0, stream[3]});
      check({31'h0, i_fpp_device_model.userMode}, 32'h1);
      check(i_fpp_device_model.nBytes, 32'h3);
      check(i_fpp_device_model.rises, cmp ? 32'hC : 32'h3);
      for (k = 0; k < 3; k = k + 1)
        check({24'h0, i_fpp_device_model.got[k]}, {24'h0, stream[k]});
    end
  endtask
  task testError;
    begin
      compress <= 1'h0;
      axiWrite(`REG_CTRL, 32'h19);
      axiWrite(`REG_DATA, 32'h5A);
      while (i_fpp_device_model.nBytes == 0) @(posedge ref_clk);
      injectErr <= 1'h1;
      rd = 32'h0;
      while (!rd[`ST_ERROR]) axiRead(`REG_STATUS);
      injectErr <= 1'h0;
      check(rd & 32'hE2, 32'h0);
      repeat (20) @(posedge ref_clk);
      check({31'h0, configByteClock}, 32'h0);
      ucA = userStartupClock;
      repeat (2) @(posedge ref_clk);
      check({31'h0, userStartupClock}, {31'h0, !ucA});
    end
  endtask
  task testNoDone;
    begin
      axiWrite(`REG_CTRL, 32'h9);
      axiWrite(`REG_DATA, {24'h0, stream[0]});
      axiWrite(`REG_DATA, {23'h0, 1'h1, stream[1]});
      rd = 32'h0;
      while (!rd[`ST_ERROR]) axiRead(`REG_STATUS);
      check(rd & 32'h116, 32'h114);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail = n_fail + 1;
    give_verdict;
  end
  initial begin
    stream[0] = 8'hA5;
    stream[1] = 8'h3C;
    stream[2] = 8'h0F;
    stream[3] = 8'hF0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'h1;
    testReset;
    testLoad(1'h0);
    testLoad(1'h1);
    testError;
    testNoDone;
    testLoad(1'h0);
    give_verdict;
  end
endmodule
